// ---- design/csu_clock_synth_unit.sv ----
// Clock synthesis unit: source select, PLL guard, postscaler, system and 3X rates
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps

// Contract
// - Postscaler divides selected clock by 1,2,4 up to 256.
// - System clock is postscaler output halved, 50% duty.
// - High-speed clock runs at three times the system clock rate.
// - Loss of PLL reference forces a fallback to the internal source and sets status.
// - Software can power down PLL, relaxation or crystal oscillator.
// - Relaxation oscillator runs 8 MHz, standbys 400 kHz, or powers down.
// - After reset the internal oscillator is selected, select bit zero.
// - Do not switch to an external source until enabled and stable.
// - Trim field occupies bits 0 to 9 of oscillator control.
// - Factory trim is loaded into factory option register at reset.
// - Bypass bit takes external clock on crystal output pin, below 8 MHz.
// - Alternate clock pin used when selected and port B configured, max 64 MHz.
module csu_clock_synth_unit
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic [2:0]                 addr_i,
    input  wire logic [15:0]                wdata_i,
    input  wire logic                       we_i,
    input  wire logic                       re_i,
    output logic      [15:0]                rdata_o,
    input  wire logic [csu_pkg::TRIM_W-1:0] factory_trim_i,
    input  wire logic                       crystal_in_pin_i,
    input  wire logic                       crystal_out_pin_i,
    input  wire logic                       alt_clock_in_pin_i,
    input  wire logic                       port_b_peripheral_enable_i,
    input  wire logic [1:0]                 port_b_function_select_i,
    output logic      [csu_pkg::TRIM_W-1:0] trim_o,
    output logic                            rosc_standby_o,
    output logic                            rosc_pd_o,
    output logic                            xosc_pd_o,
    output logic                            pll_pd_o,
    output logic                            sys_clk_o,
    output logic                            sys_tick_o,
    output logic                            hs_tick_o,
    output logic                            irq_o
);
    import csu_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0]       pll_ctrl_q;
    logic [15:0]       osc_ctrl_q;
    logic [ST_W-1:0]   status_q;
    logic [ST_W-1:0]   mask_q;
    logic [TRIM_W-1:0] fopt_q;
    logic              fopt_done_q;
    logic [ST_W-1:0]   ev;
    logic              wr_pll;
    logic              wr_osc;
    logic              ext_stable;
    logic              lor_ev;
    logic              refuse_ev;
    csu_rosc_mode_t    rosc_mode;

    assign wr_pll = we_i && addr_i == ADDR_PLL_CTRL;
    assign wr_osc = we_i && addr_i == ADDR_OSC_CTRL;

    always_comb
    begin
        case (osc_ctrl_q[ROSC_LSB +: 2])
            2'h0:    rosc_mode = ROSC_RUN;
            2'h1:    rosc_mode = ROSC_STBY;
            default: rosc_mode = ROSC_OFF;
        endcase
    end

    // Switching to an external source is refused while it is unstable
    assign refuse_ev = wr_pll && wdata_i[PLL_SRC_BIT] && !pll_ctrl_q[PLL_SRC_BIT]
                       && !ext_stable;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            pll_ctrl_q <= PLL_CTRL_RST;
        else if (wr_pll)
        begin
            pll_ctrl_q <= wdata_i;
            if (refuse_ev || lor_ev)
                pll_ctrl_q[PLL_SRC_BIT] <= 1'b0;
        end
        else if (lor_ev)
            pll_ctrl_q[PLL_SRC_BIT] <= 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            osc_ctrl_q <= OSC_CTRL_RST;
        else if (wr_osc)
            osc_ctrl_q <= wdata_i;
    end

    // Factory trim is captured on the first clock after reset release
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            fopt_q      <= '0;
            fopt_done_q <= 1'b0;
        end
        else if (!fopt_done_q)
        begin
            fopt_q      <= factory_trim_i;
            fopt_done_q <= 1'b1;
        end
    end

    assign trim_o         = osc_ctrl_q[TRIM_W-1:0];
    assign rosc_standby_o = rosc_mode == ROSC_STBY;
    assign rosc_pd_o      = rosc_mode == ROSC_OFF;
    assign xosc_pd_o      = osc_ctrl_q[XOSC_PD_BIT];
    assign pll_pd_o       = pll_ctrl_q[PLL_PD_BIT];

    // ************************************************************
    // Relaxation oscillator model
    // ************************************************************
    // Frequency is modelled on the system clock; trim acts only in analog
    logic [8:0] rosc_cnt_q;
    logic [8:0] rosc_lim;
    logic       rosc_tick;

    assign rosc_lim  = (rosc_mode == ROSC_STBY) ? 9'(ROSC_SBY_CYC - 1)
                                                : 9'(ROSC_RUN_CYC - 1);
    assign rosc_tick = rosc_mode != ROSC_OFF && rosc_cnt_q >= rosc_lim;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || rosc_mode == ROSC_OFF || rosc_tick)
            rosc_cnt_q <= '0;
        else
            rosc_cnt_q <= rosc_cnt_q + 9'h001;
    end

    // ************************************************************
    // External source and stability watch
    // ************************************************************
    logic       alt_ok;
    logic       ext_pin;
    logic       ext_pin_q;
    logic       ext_edge;
    logic [4:0] per_q;
    logic [6:0] good_q;
    logic [4:0] min_per;

    assign alt_ok   = osc_ctrl_q[ALT_SEL_BIT] && port_b_peripheral_enable_i
                      && port_b_function_select_i == 2'h1;
    assign ext_pin  = alt_ok ? alt_clock_in_pin_i
                    : osc_ctrl_q[BYPASS_BIT] ? crystal_out_pin_i
                    : (crystal_in_pin_i && !osc_ctrl_q[XOSC_PD_BIT]);
    assign min_per  = alt_ok ? 5'(ALT_MIN_CYC) : 5'(CRYSTAL_OUT_PIN_MIN_CYC);
    assign ext_edge = ext_pin && !ext_pin_q;
    assign ext_stable = good_q == 7'(STABLE_EDGES);

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            ext_pin_q <= 1'b0;
        else
            ext_pin_q <= ext_pin;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || ext_edge)
            per_q <= '0;
        else if (per_q != 5'h1f)
            per_q <= per_q + 5'h01;
    end

    // Too fast a clock or any write to oscillator control clears stability
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || wr_osc)
            good_q <= '0;
        else if (ext_edge && (per_q + 5'h01) < min_per)
            good_q <= '0;
        else if (ext_edge && !ext_stable)
            good_q <= good_q + 7'h01;
    end

    // ************************************************************
    // Source select, PLL and loss of reference
    // ************************************************************
    logic        src_ext;
    logic        ref_tick;
    logic        pll_tick;
    logic [10:0] lor_cnt_q;

    assign src_ext  = pll_ctrl_q[PLL_SRC_BIT];
    assign ref_tick = src_ext ? ext_edge : rosc_tick;
    // PLL modelled as a locked unity multiplier
    assign pll_tick = ref_tick;
    assign lor_ev   = !pll_pd_o && lor_cnt_q == 11'(LOR_TIMEOUT_CYC);

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || pll_pd_o || ref_tick || lor_ev)
            lor_cnt_q <= '0;
        else
            lor_cnt_q <= lor_cnt_q + 11'h001;
    end

    // ************************************************************
    // Postscaler, system clock and 3X clock
    // ************************************************************
    logic       post_tick;
    logic       sys_q;
    logic [9:0] hs_acc_q;
    logic [9:0] hs_thr;
    logic [POST_W-1:0] post_sel;
    logic [POST_W-1:0] hs_sel_q;

    csu_postscaler u_post (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .tick_i  (pll_tick),
        .sel_i   (pll_ctrl_q[POST_LSB +: POST_W]),
        .sel_o   (post_sel),
        .tick_o  (post_tick)
    );

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            sys_q <= 1'b0;
        else if (post_tick)
            sys_q <= !sys_q;
    end

    assign sys_clk_o  = sys_q;
    assign sys_tick_o = post_tick && sys_q;

    // Three pulses per system period: add 3 per source tick, drain one
    // system-period share per pulse; the clock is fast enough to drain
    assign hs_thr    = 10'h002 << hs_sel_q;
    assign hs_tick_o = hs_acc_q >= hs_thr;

    // A new ratio restarts the share count, else a falling ratio bursts
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            hs_sel_q <= '0;
            hs_acc_q <= '0;
        end
        else if (hs_sel_q != post_sel)
        begin
            hs_sel_q <= post_sel;
            hs_acc_q <= '0;
        end
        else
            hs_acc_q <= hs_acc_q + (pll_tick ? 10'h003 : 10'h000)
                        - (hs_tick_o ? hs_thr : 10'h000);
    end

    // ************************************************************
    // Status, mask and interrupt
    // ************************************************************
    logic ext_stable_q;

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            ext_stable_q <= 1'b0;
        else
            ext_stable_q <= ext_stable;
    end

    always_comb
    begin
        ev            = '0;
        ev[ST_LOR]    = lor_ev;
        ev[ST_REFUSE] = refuse_ev;
        ev[ST_STABLE] = ext_stable && !ext_stable_q;
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            status_q <= '0;
        else if (we_i && addr_i == ADDR_STATUS)
            status_q <= (status_q & ~wdata_i[ST_W-1:0]) | ev;
        else
            status_q <= status_q | ev;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            mask_q <= '0;
        else if (we_i && addr_i == ADDR_MASK)
            mask_q <= wdata_i[ST_W-1:0];
    end

    assign irq_o = |(status_q & mask_q);

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || !re_i)
            rdata_o <= '0;
        else
            case (addr_i)
                ADDR_PLL_CTRL: rdata_o <= pll_ctrl_q;
                ADDR_OSC_CTRL: rdata_o <= osc_ctrl_q;
                ADDR_STATUS:   rdata_o <= 16'(status_q);
                ADDR_MASK:     rdata_o <= 16'(mask_q);
                ADDR_FOPT:     rdata_o <= 16'(fopt_q);
                ADDR_STATE:    rdata_o <= {10'h000, alt_ok, sys_q,
                                           post_sel == 4'h0, ext_stable,
                                           !pll_pd_o, src_ext};
                default:       rdata_o <= 16'h0000;
            endcase
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_lor_hit;
        !pll_pd_o && lor_cnt_q == 11'(LOR_TIMEOUT_CYC);
    endsequence

    chk_reset_int: assert property (@(posedge clk_i)
        !rst_b_i |=> !src_ext && pll_pd_o)
        else $error("internal source not selected after reset");

    chk_lor_fallback: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        s_lor_hit |=> !src_ext && status_q[ST_LOR])
        else $error("loss of reference did not fall back");

    chk_switch_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $rose(src_ext) |-> $past(ext_stable))
        else $error("switched to unstable external source");

    chk_sys_toggle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $changed(sys_q) |-> $past(post_tick))
        else $error("system clock toggled without postscaler pulse");

    chk_hs_bound: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        hs_acc_q < hs_thr + 10'h006)
        else $error("3X accumulator runs away");

    chk_rosc_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        rosc_pd_o |=> rosc_cnt_q == 9'h000)
        else $error("powered down oscillator still ticks");

    chk_pll_guard: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        pll_pd_o |=> lor_cnt_q == 11'h000 || !$past(pll_pd_o))
        else $error("loss watch runs with PLL off");

    chk_fopt_load: assert property (@(posedge clk_i)
        $rose(rst_b_i) |=> fopt_q == $past(factory_trim_i))
        else $error("factory trim not captured");

    chk_irq_level: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        |(ev & mask_q) && !(we_i && addr_i == ADDR_MASK) |=> irq_o)
        else $error("unmasked event did not raise interrupt");

endmodule // csu_clock_synth_unit

// ---- design/csu_pkg.sv ----
// Constants, register map and types of the clock synthesis unit
package csu_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_HZ          = 125_000_000;
    localparam int ROSC_RUN_HZ     = 8_000_000;
    localparam int ROSC_SBY_HZ     = 400_000;
    localparam int CRYSTAL_OUT_PIN_MAX_HZ     = 8_000_000;
    localparam int ALT_MAX_HZ      = 64_000_000;
    localparam int ROSC_RUN_CYC    = CLK_HZ / ROSC_RUN_HZ;
    localparam int ROSC_SBY_CYC    = CLK_HZ / ROSC_SBY_HZ;
    // Least period of an external clock, rounded up
    localparam int CRYSTAL_OUT_PIN_MIN_CYC    = (CLK_HZ + CRYSTAL_OUT_PIN_MAX_HZ - 1) / CRYSTAL_OUT_PIN_MAX_HZ;
    localparam int ALT_MIN_CYC     = (CLK_HZ + ALT_MAX_HZ - 1) / ALT_MAX_HZ;
    localparam int STABLE_EDGES    = 64;
    localparam int LOR_TIMEOUT_CYC = 1024;
    localparam int POST_MAX_SEL    = 8;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [2:0] ADDR_PLL_CTRL = 3'h0;
    localparam logic [2:0] ADDR_OSC_CTRL = 3'h1;
    localparam logic [2:0] ADDR_STATUS   = 3'h2;
    localparam logic [2:0] ADDR_MASK     = 3'h3;
    localparam logic [2:0] ADDR_FOPT     = 3'h4;
    localparam logic [2:0] ADDR_STATE    = 3'h5;

    // pll_control_reg fields
    localparam int PLL_SRC_BIT  = 0;
    localparam int PLL_PD_BIT   = 1;
    localparam int POST_LSB     = 4;
    localparam int POST_W       = 4;
    localparam logic [15:0] PLL_CTRL_RST = 16'h0002;

    // oscillator_control_reg fields
    localparam int TRIM_W       = 10;
    localparam int BYPASS_BIT   = 10;
    localparam int ALT_SEL_BIT  = 11;
    localparam int ROSC_LSB     = 12;
    localparam int XOSC_PD_BIT  = 14;
    localparam logic [15:0] OSC_CTRL_RST = 16'h0000;

    // Status bits, one per event
    localparam int ST_LOR    = 0;
    localparam int ST_REFUSE = 1;
    localparam int ST_STABLE = 2;
    localparam int ST_W      = 3;

    typedef enum logic [1:0] {
        ROSC_RUN,
        ROSC_STBY,
        ROSC_OFF
    } csu_rosc_mode_t;

endpackage

// ---- design/csu_postscaler.sv ----
// Power-of-two postscaler that changes ratio only at a period boundary
`timescale 1ns/1ps
module csu_postscaler
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       tick_i,
    input  wire logic [csu_pkg::POST_W-1:0] sel_i,
    output logic      [csu_pkg::POST_W-1:0] sel_o,
    output logic                            tick_o
);
    import csu_pkg::*;

    logic [POST_W-1:0] sel_q;
    logic [7:0]        cnt_q;
    logic [7:0]        lim;
    logic              wrap;

    assign lim    = 8'((9'h001 << sel_q) - 9'h001);
    assign wrap   = tick_i && (cnt_q == lim);
    assign tick_o = wrap;
    assign sel_o  = sel_q;

    // New ratio is taken only when a period ends, so no short pulse
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            sel_q <= '0;
        else if (wrap || (cnt_q == 8'h00 && !tick_i))
            sel_q <= (sel_i > POST_W'(POST_MAX_SEL)) ? POST_W'(POST_MAX_SEL) : sel_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            cnt_q <= '0;
        else if (wrap)
            cnt_q <= '0;
        else if (tick_i)
            cnt_q <= cnt_q + 8'h01;
    end

    chk_post_boundary: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $changed(sel_q) |-> $past(wrap) || ($past(cnt_q) == 8'h00 && !$past(tick_i)))
        else $error("postscaler ratio changed inside a period");

    chk_post_ratio: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        cnt_q <= lim)
        else $error("postscaler count beyond its ratio");

endmodule // csu_postscaler

// ---- tb/csu_clock_synth_unit_tb.sv ----
// Self-checking testbench of the clock synthesis unit
`timescale 1ns/1ps
module csu_clock_synth_unit_tb;
    import csu_pkg::*;
    localparam logic [TRIM_W-1:0] FTRIM = 10'h2A5;
    logic              clk_i, rst_b_i, we_i, re_i, pbe, xin, xout, alt;
    logic [2:0]        addr_i;
    logic [15:0]       wdata_i, rdata_o, d;
    logic [1:0]        pbf;
    logic [TRIM_W-1:0] trim_o;
    logic              rsb, rpd, xpd, ppd, sys_clk_o, sys_tick_o, hs_tick_o, irq_o;
    logic              xin_run, xout_run, alt_run;
    logic [7:0]        xout_half, alt_half;
    int                n_errors, samples_checked, cyc, hi, lo, hs, st;

    csu_clock_synth_unit csu_clock_synth_unit_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
        .factory_trim_i(FTRIM), .crystal_in_pin_i(xin), .crystal_out_pin_i(xout),
        .alt_clock_in_pin_i(alt), .port_b_peripheral_enable_i(pbe),
        .port_b_function_select_i(pbf), .trim_o(trim_o), .rosc_standby_o(rsb),
        .rosc_pd_o(rpd), .xosc_pd_o(xpd), .pll_pd_o(ppd), .sys_clk_o(sys_clk_o),
        .sys_tick_o(sys_tick_o), .hs_tick_o(hs_tick_o), .irq_o(irq_o));
    csu_ext_clock xin_src (.clk_i(clk_i), .run_i(xin_run), .half_i(8'h08), .pin_o(xin));
    csu_ext_clock xout_src (.clk_i(clk_i), .run_i(xout_run), .half_i(xout_half), .pin_o(xout));
    csu_ext_clock alt_src (.clk_i(clk_i), .run_i(alt_run), .half_i(alt_half), .pin_o(alt));

    // ************************************************************
    // Clock, timeout and shared tasks
    // ************************************************************
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // Postscaler sweep dominates the run at about 65000 cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_i);
        we_i <= 1'b1; addr_i <= a; wdata_i <= v;
        @(posedge clk_i);
        we_i <= 1'b0;
        // Outputs of the write settle before the caller looks at them
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge clk_i);
        re_i <= 1'b1; addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    // One whole system clock period, measured from a rising edge
    task automatic meas();
        hi = 0; lo = 0; hs = 0; st = 0;
        @(negedge clk_i);
        while (sys_clk_o !== 1'b0) @(negedge clk_i);
        while (sys_clk_o !== 1'b1) @(negedge clk_i);
        while (sys_clk_o === 1'b1)
        begin
            hi++; hs += hs_tick_o; st += sys_tick_o;
            @(negedge clk_i);
        end
        while (sys_clk_o === 1'b0)
        begin
            lo++; hs += hs_tick_o; st += sys_tick_o;
            @(negedge clk_i);
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rd(ADDR_PLL_CTRL, d); check("pll_ctrl", d, 16'h0002);
        check("pll_pd", 16'(ppd), 16'h0001);
        rd(ADDR_FOPT, d); check("fopt", d, 16'(FTRIM));
        wr(ADDR_FOPT, 16'h0000);
        rd(ADDR_FOPT, d); check("fopt ro", d, 16'(FTRIM));
        rd(3'h6, d); check("unmapped", d, 16'h0000);
        $display("reset test done");
    endtask

    task automatic t_osc();
        for (int m = 3; m >= 0; m--)
        begin
            wr(ADDR_OSC_CTRL, 16'(m << ROSC_LSB) | 16'h43FF);
            check("trim", 16'(trim_o), 16'h03FF);
            check("standby", 16'(rsb), 16'(m == 1));
            check("rosc pd", 16'(rpd), 16'(m >= 2));
            check("xosc pd", 16'(xpd), 16'h0001);
        end
        wr(ADDR_OSC_CTRL, 16'(FTRIM));
        check("trim copy", 16'(trim_o), 16'(FTRIM));
        wr(ADDR_PLL_CTRL, 16'h0000); check("pll on", 16'(ppd), 16'h0000);
        wr(ADDR_PLL_CTRL, 16'h0002);
        $display("oscillator control test done");
    endtask

    task automatic t_refuse();
        wr(ADDR_STATUS, 16'h0007); wr(ADDR_MASK, 16'h0002);
        wr(ADDR_PLL_CTRL, 16'h0003);
        rd(ADDR_PLL_CTRL, d); check("src refused", d, 16'h0002);
        rd(ADDR_STATUS, d); check("status", d, 16'h0002);
        check("irq set", 16'(irq_o), 16'h0001);
        wr(ADDR_MASK, 16'h0000); check("irq masked", 16'(irq_o), 16'h0000);
        wr(ADDR_MASK, 16'h0002); wr(ADDR_STATUS, 16'h0002);
        check("irq clr", 16'(irq_o), 16'h0000);
        rd(ADDR_STATUS, d); check("status clr", d, 16'h0000);
        $display("refused switch test done");
    endtask

    task automatic t_post();
        for (int s = 0; s <= POST_MAX_SEL; s++)
        begin
            wr(ADDR_PLL_CTRL, 16'((s << POST_LSB) | 2));
            meas(); meas();
            check("high time", 16'(hi), 16'((1 << s) * ROSC_RUN_CYC));
            check("low time", 16'(lo), 16'(hi));
            check("hs ticks", 16'(hs), 16'h0003);
            check("sys ticks", 16'(st), 16'h0001);
        end
        wr(ADDR_PLL_CTRL, 16'h0002);
        $display("postscaler test done");
    endtask

    task automatic t_ext();
        xin_run <= 1'b1;
        wr(ADDR_OSC_CTRL, 16'(1 << XOSC_PD_BIT));
        repeat (STABLE_EDGES * 16 + 100) @(posedge clk_i);
        rd(ADDR_STATE, d); check("xosc off", d & 16'h0004, 16'h0000);
        wr(ADDR_OSC_CTRL, 16'h0000);
        repeat (STABLE_EDGES * 16 + 100) @(posedge clk_i);
        rd(ADDR_STATE, d); check("xosc stable", d & 16'h0004, 16'h0004);
        xin_run <= 1'b0;
        xout_half <= 8'h08; xout_run <= 1'b1;
        wr(ADDR_STATUS, 16'h0007);
        wr(ADDR_OSC_CTRL, 16'(1 << BYPASS_BIT));
        repeat (STABLE_EDGES * 16 + 100) @(posedge clk_i);
        rd(ADDR_STATUS, d); check("ext stable", d & 16'h0004, 16'h0004);
        wr(ADDR_PLL_CTRL, 16'h0003);
        rd(ADDR_PLL_CTRL, d); check("src ext", d, 16'h0003);
        meas(); meas(); check("bypass high", 16'(hi), 16'h0010);
        wr(ADDR_PLL_CTRL, 16'h0001);
        xout_run <= 1'b0;
        repeat (LOR_TIMEOUT_CYC + 100) @(posedge clk_i);
        rd(ADDR_STATUS, d); check("lor", d & 16'h0001, 16'h0001);
        rd(ADDR_STATE, d); check("src forced", d & 16'h0001, 16'h0000);
        $display("external clock test done");
    endtask

    task automatic t_alt();
        wr(ADDR_PLL_CTRL, 16'h0002); wr(ADDR_STATUS, 16'h0007);
        pbe <= 1'b1; alt_half <= 8'h01; alt_run <= 1'b1;
        wr(ADDR_OSC_CTRL, 16'(1 << ALT_SEL_BIT));
        rd(ADDR_STATE, d); check("alt unrouted", d & 16'h0020, 16'h0000);
        pbf <= 2'h1;
        repeat (STABLE_EDGES * 2 + 100) @(posedge clk_i);
        rd(ADDR_STATE, d); check("alt state", d & 16'h0024, 16'h0024);
        wr(ADDR_PLL_CTRL, 16'h0003);
        meas(); meas(); check("alt high", 16'(hi), 16'h0002);
        $display("alternate clock test done");
    endtask

    initial
    begin
        rst_b_i = 1'b0; we_i = 1'b0; re_i = 1'b0; addr_i = 3'h0; wdata_i = 16'h0000;
        pbe = 1'b0; pbf = 2'h0; xin_run = 1'b0; xout_run = 1'b0; alt_run = 1'b0;
        xout_half = 8'h08; alt_half = 8'h01;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_osc();
        t_refuse();
        t_post();
        t_ext();
        t_alt();
        end_of_test();
    end
endmodule // csu_clock_synth_unit_tb

// ---- tb/csu_ext_clock.sv ----
// External clock source model standing on the far side of the clock synthesis unit
`timescale 1ns/1ps
module csu_ext_clock
(
    input  wire logic       clk_i,
    input  wire logic       run_i,
    input  wire logic [7:0] half_i,
    output logic            pin_o
);
    logic [7:0] cnt_q;
    logic       ph_q;

    // ************************************************************
    // Clock generator
    // ************************************************************
    // Half period in system cycles; the bench keeps the bypass pin under
    // 8 MHz and the alternate pin at or under 64 MHz
    always_ff @(posedge clk_i)
    begin
        if (!run_i)
        begin
            cnt_q <= 8'h00;
            ph_q  <= 1'b0;
        end
        else if (cnt_q + 8'h01 >= half_i)
        begin
            cnt_q <= 8'h00;
            ph_q  <= ~ph_q;
        end
        else
        begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // A stopped source leaves its pin grounded, never at the last level
    assign pin_o = run_i & ph_q;
endmodule // csu_ext_clock
